// [msd_pkg.sv]
// Shared constants and types for the memory space decoder
package msd_pkg;

  // ----------------------------------------
  // Program memory
  // ----------------------------------------
  localparam int CODE_MAX_BYTES = 8192;
  localparam int CODE_MID_BYTES = 4096;
  localparam int CODE_MIN_BYTES = 2048;
  localparam int CODE_SPACE_BYTES = 65536;
  localparam int CODE_RESERVED_BYTES = 512;
  localparam logic [7:0] CODE_ERASED = 8'hff;

  // ----------------------------------------
  // Internal data memory
  // ----------------------------------------
  localparam int IRAM_BYTES = 256;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [2:0] BANK_REGS_LSB = 3'h0;
  localparam logic [7:0] SP_RESET = 8'h07;

  // ----------------------------------------
  // Locally held special registers
  // ----------------------------------------
  localparam logic [7:0] SP_ADDR = 8'h81;
  localparam logic [7:0] XPAGE_ADDR = 8'haa;
  localparam logic [7:0] XPAGE_RESET = 8'h00;
  localparam int XPAGE_BIT = 0;

  // ----------------------------------------
  // On-chip external RAM
  // ----------------------------------------
  localparam int XRAM_BYTES = 512;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int ANSWER_EDGES = 2;

  typedef enum logic [2:0] {
    K_CODE,
    K_DIRECT,
    K_INDIRECT,
    K_BIT,
    K_XDPTR,
    K_XIND,
    K_PUSH,
    K_POP
  } msd_kind_t;

endpackage : msd_pkg

// [msd_xram_if.sv]
// Carrier between the decoder and its external RAM store
`timescale 1ns/10ps
`default_nettype none
interface msd_xram_if;
  logic req;
  logic wr;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport user (output req, output wr, output addr, output wdata, input rdata);
  modport store (input req, input wr, input addr, input wdata, output rdata);
endinterface : msd_xram_if
`default_nettype wire

// [msd_xram_store.sv]
// On-chip external RAM array with combinational read
`timescale 1ns/10ps
`default_nettype none
module msd_xram_store import msd_pkg::*; #(
  parameter int BYTES = XRAM_BYTES
) (
  input wire logic ref_clk,
  msd_xram_if.store xif
);

  localparam int AW = $clog2(BYTES);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (BYTES != XRAM_BYTES) begin : g_bad_size
    $error("msd_xram_store: size must match the nine-bit address");
  end

  logic [7:0] mem [BYTES];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (xif.req && xif.wr) begin
      mem[xif.addr[AW-1:0]] <= xif.wdata; // see R15
    end
  end

  assign xif.rdata = mem[xif.addr[AW-1:0]];

endmodule : msd_xram_store
`default_nettype wire

// [msd_mcu_memory_space_decoder.sv]
// Memory space decoder: program, internal, bit, stack and external RAM access
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1 - Largest build holds 8192 program bytes at 0x0000-0x1FFF of a 64 kB space.
// R2 - Top 512 program bytes 0x1E00-0x1FFF are kept from user storage.
// R3 - Program size is a parameter: 8192, 4096 or 2048 bytes.
// R4 - Program memory is read-only to code; single bytes readable by code reads.
// R5 - Internal RAM covers 0x00-0xFF; lower half reached direct and indirect.
// R6 - Above 0x7F direct goes to special registers, indirect to upper RAM.
// R7 - 0x00-0x1F is four banks of eight registers, one chosen by two bits.
// R8 - Bank value n places working registers at n*8 to n*8+7.
// R9 - Indirect pointers come only from index registers zero and one of active bank.
// R10 - Bytes 0x20-0x2F give bits 0x00-0x7F; bit = 8*(byte-0x20)+position.
// R11 - Bit versus byte access follows the access kind, never the address.
// R12 - Push writes at pointer plus one, then pointer increments.
// R13 - Reset sets stack pointer to 0x07, so first push lands at 0x08.
// R14 - Stack may sit anywhere in 256 bytes and grow to all of them.
// R15 - 512 on-chip bytes sit in external space via pointer or register indirect.
// R16 - Eight-bit external moves take the upper address byte from the page register.
// R17 - Sixteen-bit external moves ignore upper seven bits; RAM repeats every 0x0200.
// R18 - Page register bits 7-1 read zero, ignore writes; bit 0 resets 0, selects page.
// R19 - Page register sits at direct special address 0xAA.
// R20 - Every read answers a fixed two clock edges after being taken.
module msd_mcu_memory_space_decoder import msd_pkg::*; #(
  parameter int CODE_BYTES = CODE_MAX_BYTES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic acc_req,
  input wire msd_kind_t acc_kind,
  input wire logic [15:0] acc_addr,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_wbit,
  input wire logic [1:0] bank_select_field,
  output logic acc_ready,
  output logic acc_rvalid,
  output logic [7:0] acc_rdata,
  output logic acc_rbit,
  output logic sfr_req,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] stack_top_pointer,
  output logic xram_page_bit,
  input wire logic fill_en,
  input wire logic [15:0] fill_addr,
  input wire logic [7:0] fill_data
);

  localparam int CAW = $clog2(CODE_BYTES);
  localparam int USER_BYTES = (CODE_BYTES == CODE_MAX_BYTES) ?
                              CODE_BYTES - CODE_RESERVED_BYTES : CODE_BYTES;
  localparam logic [16:0] USER_LIMIT = 17'(USER_BYTES);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (CODE_BYTES != CODE_MAX_BYTES && CODE_BYTES != CODE_MID_BYTES &&
      CODE_BYTES != CODE_MIN_BYTES) begin : g_bad_code // see R3
    $error("msd_mcu_memory_space_decoder: unsupported program size");
  end

  // ----------------------------------------
  // State and request capture
  // ----------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RESOLVE, ST_ACCESS} msd_state_t;

  msd_state_t state_q;
  msd_kind_t kind_q;
  logic [15:0] addr_q;
  logic wr_q;
  logic [7:0] wdata_q;
  logic wbit_q;
  logic [1:0] bank_q;
  logic [7:0] ea_q;
  logic [8:0] xaddr_q;
  logic [2:0] bitpos_q;
  logic to_sfr_q;
  logic [7:0] sp_q;
  logic page_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic rbit_q;

  logic [7:0] iram [IRAM_BYTES];
  logic [7:0] code_mem [CODE_BYTES];

  msd_xram_if xif ();

  msd_xram_store #(.BYTES(XRAM_BYTES)) u_xram (
    .ref_clk(ref_clk),
    .xif(xif)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (acc_req) begin
            state_q <= ST_RESOLVE;
          end
        end
        ST_RESOLVE: begin
          state_q <= ST_ACCESS;
        end
        ST_ACCESS: begin
          state_q <= ST_IDLE; // see R20
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Request fields are held until the answer, so the core may change them freely
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      kind_q <= K_CODE;
      addr_q <= 16'h0000;
      wr_q <= 1'b0;
      wdata_q <= 8'h00;
      wbit_q <= 1'b0;
      bank_q <= 2'h0;
    end else if (state_q == ST_IDLE && acc_req) begin
      kind_q <= acc_kind;
      addr_q <= acc_addr;
      wr_q <= acc_wr;
      wdata_q <= acc_wdata;
      wbit_q <= acc_wbit;
      bank_q <= bank_select_field; // see R7
    end
  end

  // ----------------------------------------
  // Address resolution
  // ----------------------------------------
  logic [7:0] idx_addr;
  logic [7:0] ptr;

  // Working register i of bank n sits at n*8+i
  assign idx_addr = {3'h0, bank_q, 2'h0, addr_q[0]}; // see R8
  assign ptr = iram[idx_addr]; // see R9

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ea_q <= 8'h00;
      xaddr_q <= 9'h000;
      bitpos_q <= 3'h0;
      to_sfr_q <= 1'b0;
    end else if (state_q == ST_RESOLVE) begin
      bitpos_q <= addr_q[2:0];
      to_sfr_q <= 1'b0;
      ea_q <= addr_q[7:0];
      xaddr_q <= addr_q[8:0];
      case (kind_q)
        K_DIRECT: begin
          to_sfr_q <= (addr_q[7:0] >= UPPER_BASE); // see R5, R6
        end
        K_INDIRECT: begin
          ea_q <= ptr; // see R6
        end
        K_BIT: begin
          if (addr_q[7:0] < UPPER_BASE) begin
            ea_q <= BIT_BYTE_BASE + {4'h0, addr_q[6:3]}; // see R10
          end else begin
            ea_q <= {addr_q[7:3], 3'h0};
            to_sfr_q <= 1'b1;
          end
        end
        K_PUSH: begin
          ea_q <= sp_q + 8'h01; // see R12, R14
        end
        K_POP: begin
          ea_q <= sp_q;
        end
        K_XDPTR: begin
          xaddr_q <= addr_q[8:0]; // see R17
        end
        K_XIND: begin
          xaddr_q <= {page_q, ptr}; // see R16, R9
        end
        default: begin
          to_sfr_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic in_access;
  logic is_bit;
  logic is_iram;
  logic is_xram;
  logic hit_sp;
  logic hit_page;
  logic [7:0] iram_byte;
  logic [7:0] iram_bit_merge;
  logic [7:0] sfr_bit_merge;
  logic [7:0] local_sfr;

  assign in_access = (state_q == ST_ACCESS);
  assign is_bit = (kind_q == K_BIT); // see R11
  assign is_xram = (kind_q == K_XDPTR) || (kind_q == K_XIND);
  assign is_iram = !to_sfr_q && (kind_q == K_DIRECT || kind_q == K_INDIRECT ||
                   kind_q == K_BIT || kind_q == K_PUSH || kind_q == K_POP);
  assign hit_sp = to_sfr_q && !is_bit && (ea_q == SP_ADDR);
  assign hit_page = to_sfr_q && !is_bit && (ea_q == XPAGE_ADDR); // see R19
  assign iram_byte = iram[ea_q];

  always_comb begin
    iram_bit_merge = iram_byte;
    iram_bit_merge[bitpos_q] = wbit_q;
    sfr_bit_merge = sfr_rdata;
    sfr_bit_merge[bitpos_q] = wbit_q;
  end

  always_comb begin
    local_sfr = 8'h00;
    if (hit_sp) begin
      local_sfr = sp_q;
    end else if (hit_page) begin
      local_sfr[XPAGE_BIT] = page_q; // see R18
    end
  end

  // Other special registers live outside; a bit write is a read-modify-write
  // of the whole byte, which costs a combinational path from sfr_rdata
  assign sfr_req = in_access && to_sfr_q && !hit_sp && !hit_page; // see R6
  assign sfr_wr = sfr_req && (wr_q || is_bit && wr_q);
  assign sfr_addr = ea_q;
  assign sfr_wdata = is_bit ? sfr_bit_merge : wdata_q;

  // Pop never writes, push always does
  logic iram_we;
  assign iram_we = in_access && is_iram && kind_q != K_POP && (wr_q || kind_q == K_PUSH);

  // ----------------------------------------
  // Internal RAM storage
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (iram_we) begin
      iram[ea_q] <= is_bit ? iram_bit_merge : wdata_q; // see R5, R10, R12
    end
  end

  // ----------------------------------------
  // External RAM port
  // ----------------------------------------
  assign xif.req = in_access && is_xram; // see R15
  assign xif.wr = wr_q;
  assign xif.addr = xaddr_q;
  assign xif.wdata = wdata_q;

  // ----------------------------------------
  // Program memory
  // ----------------------------------------
  // No reset on the array; only fills below the reserved top region land
  always_ff @(posedge ref_clk) begin
    if (fill_en && {1'b0, fill_addr} < USER_LIMIT) begin
      code_mem[fill_addr[CAW-1:0]] <= fill_data; // see R2
    end
  end

  logic [7:0] code_byte;
  always_comb begin
    code_byte = CODE_ERASED;
    if ({1'b0, addr_q} < USER_LIMIT) begin
      code_byte = code_mem[addr_q[CAW-1:0]]; // see R1, R3
    end
  end

  // ----------------------------------------
  // Stack pointer and page register
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sp_q <= SP_RESET; // see R13
    end else if (in_access) begin
      if (kind_q == K_PUSH) begin
        sp_q <= ea_q; // see R12
      end else if (kind_q == K_POP) begin
        sp_q <= sp_q - 8'h01;
      end else if (hit_sp && wr_q) begin
        sp_q <= wdata_q; // see R14
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      page_q <= XPAGE_RESET[XPAGE_BIT];
    end else if (in_access && hit_page && wr_q) begin
      page_q <= wdata_q[XPAGE_BIT]; // see R18
    end
  end

  // ----------------------------------------
  // Answer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rbit_q <= 1'b0;
    end else begin
      rvalid_q <= in_access; // see R20
      if (in_access) begin
        if (kind_q == K_CODE) begin
          rdata_q <= code_byte; // see R4
        end else if (is_xram) begin
          rdata_q <= xif.rdata;
        end else if (hit_sp || hit_page) begin
          rdata_q <= local_sfr;
        end else if (to_sfr_q) begin
          rdata_q <= sfr_rdata;
        end else begin
          rdata_q <= iram_byte;
        end
        rbit_q <= to_sfr_q ? sfr_rdata[bitpos_q] : iram_byte[bitpos_q];
      end
    end
  end

  assign acc_ready = (state_q == ST_IDLE);
  assign acc_rvalid = rvalid_q;
  assign acc_rdata = rdata_q;
  assign acc_rbit = rbit_q;
  assign stack_top_pointer = sp_q;
  assign xram_page_bit = page_q;

endmodule : msd_mcu_memory_space_decoder
`default_nettype wire

// [msd_chk_sva.sv]
// Port-level assertions for the memory space decoder
`timescale 1ns/10ps
`default_nettype none
module msd_chk_sva import msd_pkg::*; #(
  parameter int CODE_BYTES = CODE_MAX_BYTES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic acc_req,
  input wire msd_kind_t acc_kind,
  input wire logic [15:0] acc_addr,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_ready,
  input wire logic acc_rvalid,
  input wire logic [7:0] acc_rdata,
  input wire logic sfr_req,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] stack_top_pointer,
  input wire logic xram_page_bit
);
  // Only the largest build keeps the factory area back
  localparam logic [15:0] USER_TOP = (CODE_BYTES == 8192) ? 16'h1e00 : 16'(CODE_BYTES);
  logic take;
  assign take = acc_req && acc_ready;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_ANSWER: assert property (take |-> ##1 !acc_rvalid ##1 !acc_rvalid ##1 acc_rvalid)
    else $error("answer not at fixed latency");
  AST_BUSY: assert property (take |=> !acc_ready [*2] ##1 acc_ready)
    else $error("ready window wrong");
  AST_PULSE: assert property (acc_rvalid |=> !acc_rvalid)
    else $error("answer longer than one cycle");
  AST_SP_RST: assert property ($fell(reset) |-> stack_top_pointer == 8'h07 && !xram_page_bit)
    else $error("reset values wrong");
  AST_PUSH: assert property (take && acc_kind == K_PUSH |->
    ##3 stack_top_pointer == 8'($past(stack_top_pointer, 3) + 8'h01))
    else $error("push did not step pointer up");
  AST_POP: assert property (take && acc_kind == K_POP |->
    ##3 stack_top_pointer == 8'($past(stack_top_pointer, 3) - 8'h01))
    else $error("pop did not step pointer down");
  AST_SFR_LOCAL: assert property (sfr_req |-> sfr_addr != 8'h81 && sfr_addr != 8'haa)
    else $error("local register sent outside");
  AST_DIRECT_SFR: assert property (take && acc_kind == K_DIRECT && acc_addr[7] &&
    acc_addr[7:0] != 8'h81 && acc_addr[7:0] != 8'haa |->
    ##2 sfr_req && sfr_addr == 8'($past(acc_addr, 2)))
    else $error("direct upper access missed register space");
  AST_BIT_SFR: assert property (take && acc_kind == K_BIT && acc_addr[7] |->
    ##2 sfr_req && sfr_addr == {$past(acc_addr[7:3], 2), 3'h0})
    else $error("upper bit access missed its register byte");
  AST_RAM_ONLY: assert property (take && (acc_kind == K_INDIRECT ||
    (acc_kind == K_DIRECT && !acc_addr[7])) |-> ##1 !sfr_req [*2])
    else $error("RAM access leaked to register space");
  AST_PAGE: assert property (take && acc_kind == K_DIRECT && acc_wr &&
    acc_addr[7:0] == 8'haa |-> ##3 xram_page_bit == $past(acc_wdata[0], 3))
    else $error("page bit not written");
  AST_RESERVED: assert property (take && acc_kind == K_CODE && !acc_wr &&
    acc_addr >= USER_TOP |-> ##3 acc_rdata == 8'hff)
    else $error("reserved code area readable");
endmodule : msd_chk_sva
`default_nettype wire

// [msd_sfr_model.sv]
// Far-side model of the outside special register space
`timescale 1ns/10ps
`default_nettype none
module msd_sfr_model (
  input wire logic ref_clk,
  input wire logic sfr_req,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata
);
  logic [7:0] regs_q [128];
  initial for (int i = 0; i < 128; i++) regs_q[i] = 8'ha5;
  // Outside a request the bus shows junk so a stale sample cannot pass
  assign sfr_rdata = sfr_req ? regs_q[sfr_addr[6:0]] : ~regs_q[sfr_addr[6:0]];
  always @(posedge ref_clk) if (sfr_req && sfr_wr) regs_q[sfr_addr[6:0]] <= sfr_wdata;
endmodule : msd_sfr_model
`default_nettype wire

// [test_mcu_memory_space_decoder.sv]
// Self-checking testbench for the memory space decoder
`timescale 1ns/10ps
`default_nettype none
module test_mcu_memory_space_decoder import msd_pkg::*; ;
  logic ref_clk = 0, reset = 1, acc_req = 0, acc_wr = 0, acc_wbit = 0, fill_en = 0;
  msd_kind_t acc_kind = K_CODE;
  logic [15:0] acc_addr = 0, fill_addr = 0;
  logic [7:0] acc_wdata = 0, fill_data = 0, got;
  logic [1:0] bank_select_field = 0;
  logic acc_ready, acc_rvalid, acc_rbit, sfr_req, sfr_wr, xram_page_bit;
  logic [7:0] acc_rdata, sfr_addr, sfr_wdata, sfr_rdata, stack_top_pointer;
  int mismatches = 0, compares = 0, cycles = 0;

  always #50 ref_clk = ~ref_clk;

  msd_mcu_memory_space_decoder #(.CODE_BYTES(8192)) DUT (.ref_clk, .reset, .acc_req,
    .acc_kind, .acc_addr, .acc_wr, .acc_wdata, .acc_wbit, .bank_select_field, .acc_ready,
    .acc_rvalid, .acc_rdata, .acc_rbit, .sfr_req, .sfr_wr, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .stack_top_pointer, .xram_page_bit, .fill_en, .fill_addr, .fill_data);
  msd_sfr_model sfr_far (.ref_clk, .sfr_req, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_rdata);

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task close_out;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // One access; qualifiers held until the taking edge has passed
  task acc(input msd_kind_t k, input logic [15:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    #1;
    // Ready seen settled here still stands at the next edge, so that edge takes the request
    while (acc_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    acc_kind = k;
    acc_addr = a;
    acc_wr = w;
    acc_wdata = d;
    acc_wbit = d[0];
    acc_req = 1;
    @(posedge ref_clk);
    #1;
    acc_req = 0;
    n = 0;
    while (acc_rvalid !== 1'b1 && n < 6) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({7'h00, acc_rvalid}, 8'h01);
    chk(8'(n), 8'(ANSWER_EDGES));
    got = (k == K_BIT) ? {7'h00, acc_rbit} : acc_rdata;
  endtask : acc

  // Ceiling well above the some 190 cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      $display("Error t=%0t cycles %h limit %h", $time, cycles, 3000);
      mismatches++;
      close_out;
    end
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    reset = 0;
    chk(stack_top_pointer, 8'h07);
    chk({7'h00, xram_page_bit}, 8'h00);
    fill_en = 1;
    fill_addr = 16'h0010;
    fill_data = 8'h5a;
    @(posedge ref_clk);
    #1;
    fill_addr = 16'h1e00;
    fill_data = 8'h33;
    @(posedge ref_clk);
    #1;
    fill_en = 0;
    acc(K_CODE, 16'h0010, 1'b1, 8'h00);
    acc(K_CODE, 16'h0010, 1'b0, 8'h00);
    chk(got, 8'h5a);
    acc(K_CODE, 16'h1e00, 1'b0, 8'h00);
    chk(got, 8'hff);
    for (int b = 0; b < 4; b++) begin
      bank_select_field = 2'(b);
      acc(K_DIRECT, 16'(b * 8 + 1), 1'b1, 8'(8'h40 + b));
      acc(K_DIRECT, 16'(8'h40 + b), 1'b1, 8'(8'hc0 + b));
      acc(K_INDIRECT, 16'h0001, 1'b0, 8'h00);
      chk(got, 8'(8'hc0 + b));
    end
    bank_select_field = 2'b10;
    acc(K_DIRECT, 16'h0011, 1'b1, 8'h90);
    acc(K_INDIRECT, 16'h0001, 1'b1, 8'h77);
    acc(K_INDIRECT, 16'h0001, 1'b0, 8'h00);
    chk(got, 8'h77);
    acc(K_DIRECT, 16'h0090, 1'b0, 8'h00);
    chk(got, 8'ha5);
    acc(K_DIRECT, 16'h0098, 1'b1, 8'h3c);
    acc(K_BIT, 16'h0099, 1'b1, 8'h01);
    acc(K_BIT, 16'h009d, 1'b0, 8'h00);
    chk(got, 8'h01);
    acc(K_DIRECT, 16'h0098, 1'b0, 8'h00);
    chk(got, 8'h3e);
    acc(K_DIRECT, 16'h0013, 1'b1, 8'he6);
    acc(K_DIRECT, 16'h0022, 1'b1, 8'h08);
    acc(K_BIT, 16'h0013, 1'b0, 8'h00);
    chk(got, 8'h01);
    acc(K_BIT, 16'h0013, 1'b1, 8'h00);
    acc(K_DIRECT, 16'h0022, 1'b0, 8'h00);
    chk(got, 8'h00);
    acc(K_DIRECT, 16'h0013, 1'b0, 8'h00);
    chk(got, 8'he6);
    acc(K_PUSH, 16'h0000, 1'b1, 8'hab);
    chk(stack_top_pointer, 8'h08);
    acc(K_DIRECT, 16'h0008, 1'b0, 8'h00);
    chk(got, 8'hab);
    acc(K_POP, 16'h0000, 1'b0, 8'h00);
    chk(got, 8'hab);
    chk(stack_top_pointer, 8'h07);
    acc(K_DIRECT, 16'h0081, 1'b1, 8'hfe);
    acc(K_PUSH, 16'h0000, 1'b1, 8'h5c);
    acc(K_DIRECT, 16'h0011, 1'b1, 8'hff);
    acc(K_INDIRECT, 16'h0001, 1'b0, 8'h00);
    chk(got, 8'h5c);
    acc(K_DIRECT, 16'h0081, 1'b0, 8'h00);
    chk(got, 8'hff);
    acc(K_DIRECT, 16'h00aa, 1'b1, 8'hff);
    acc(K_DIRECT, 16'h00aa, 1'b0, 8'h00);
    chk(got, 8'h01);
    acc(K_DIRECT, 16'h0010, 1'b1, 8'h30);
    acc(K_XIND, 16'h0000, 1'b1, 8'h6e);
    acc(K_XDPTR, 16'hfd30, 1'b0, 8'h00);
    chk(got, 8'h6e);
    acc(K_XDPTR, 16'h0030, 1'b1, 8'h21);
    acc(K_DIRECT, 16'h00aa, 1'b1, 8'h00);
    acc(K_XIND, 16'h0000, 1'b0, 8'h00);
    chk(got, 8'h21);
    close_out;
  end
endmodule : test_mcu_memory_space_decoder

bind msd_mcu_memory_space_decoder msd_chk_sva #(.CODE_BYTES(CODE_BYTES)) chk_i (.ref_clk,
  .reset, .acc_req, .acc_kind, .acc_addr, .acc_wr, .acc_wdata, .acc_ready, .acc_rvalid,
  .acc_rdata, .sfr_req, .sfr_addr, .stack_top_pointer, .xram_page_bit);
`default_nettype wire
